// ---- design/eifd_diag.sv ----
// How it works
// - over-limit frequency on one encoder input gives that input's own code
// - several inputs over limit give the combined code, one bit per input
// - no-direction error while a direction sensor has not yet moved
// - true and complement tracks disagreeing on direction give per-sensor code
// - first sensor A versus complement mismatch, coded by complement input
// - second sensor A and B complement mismatches have separate codes
// - A and B edge counts drifting apart give per-sensor frequency-difference code
// - stuck faults report fixed upper part plus one cause byte
// - even cause bits stuck-high, odd stuck-low, pairs per input
// - partner track moving while this one stays still is a stuck fault
// - still low track is stuck-low, covering ground short or cable break
// - A and B edges closer than the minimum give per-sensor phase code
// - A and B edges together, losing a combined edge, give phase code
// - collective error output is high while any error flag is set
// - any detected fault forces release outputs low
`timescale 1ns/10ps
`default_nettype none
module eifd_diag
  import eifd_pkg::*;
#(
  parameter int GAP_CYC   = FREQ_GAP_CYC,
  parameter int PHASE_CYC = PHASE_MIN_CYC,
  parameter int DISC_N    = DISC_CYC,
  parameter int STUCK_N   = STUCK_EDGES
)
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  encIn,
  input  wire logic [1:0]  cfgWiring,
  input  wire logic [1:0]  cfgDirSensor,
  input  wire logic        cfgSecondSensor,
  input  wire logic        errClear,
  input  wire logic [1:0]  releaseReq,
  output logic [1:0]       releaseOut,
  output logic             errAny,
  output logic [31:0]      errCode,
  output logic [6:0]       errFlags,
  output logic [7:0]       stuckCause,
  output logic [3:0]       freqMask
);
  typedef struct packed {
    logic [3:0]      freqMask;
    logic [1:0]      phase;
    logic [1:0]      fdiff;
    logic [1:0]      dirKnown;
    logic [1:0]      lastB;
    logic [1:0][1:0] runCnt;
    logic [1:0][7:0] phCnt;
    logic [3:0]      compl;
    logic            dirDisc;
    logic            dirT;
    logic            dirTv;
    logic            dirC;
    logic            dirCv;
    logic [7:0]      discA;
    logic [7:0]      discB;
    logic [6:0]      flags;
    logic            any;
    logic [31:0]     code;
    logic [1:0]      rel;
  } eifd_state_t;

  eifd_state_t st_reg;
  eifd_state_t st_next;
  logic [3:0]  lvl;
  logic [3:0]  rise;
  logic [3:0]  fall;
  logic [3:0]  edgeAny;
  logic [3:0]  overFreq;
  logic [3:0]  stHi;
  logic [3:0]  stLo;
  logic [1:0]  aIdx [2];
  logic [1:0]  bIdx [2];
  logic [1:0]  sValid;
  logic [1:0]  ea;
  logic [1:0]  eb;
  logic [1:0]  pA;
  logic [1:0]  pB;
  logic        useCompl;
  logic        noDirNow;
  logic [1:0]  sensNum;
  logic [7:0]  stuckByte;

  if (PHASE_CYC < 1 || PHASE_CYC > 254 || DISC_N < 1 || DISC_N > 254)
  begin : g_chk
    $error("eifd_diag: parameter out of range");
  end

  // ==========================================================================
  // per-input monitors
  for (genvar i = 0; i < 4; i++)
  begin : g_mon
    eifd_track_mon #(.GAP_CYC(GAP_CYC), .STUCK_N(STUCK_N)) u_mon (
      .clk         (clk),
      .arst_n      (arst_n),
      .pinIn       (encIn[i]),
      .partnerEdge (edgeAny[(cfgWiring == WIRE_ANTI_C2) ? (i ^ 2) : (i ^ 1)]),
      .clear       (errClear),
      .level       (lvl[i]),
      .rise        (rise[i]),
      .fall        (fall[i]),
      .overFreq    (overFreq[i]),
      .stuckHigh   (stHi[i]),
      .stuckLow    (stLo[i])
    );
    assign stuckByte[2*i]   = stHi[i];
    assign stuckByte[2*i+1] = stLo[i];
  end
  assign edgeAny = rise | fall;

  // ==========================================================================
  // track assignment per wiring
  always_comb
  begin
    aIdx[0]  = 2'd0;
    bIdx[0]  = 2'd1;
    aIdx[1]  = 2'd2;
    bIdx[1]  = 2'd3;
    sValid   = 2'b00;
    pA       = 2'd1;
    pB       = 2'd2;
    useCompl = 1'b1;
    case (cfgWiring)
      WIRE_TWO_AB:
      begin
        sValid   = 2'b11;
        useCompl = 1'b0;
      end
      WIRE_ANTI_C2:
      begin
        bIdx[0] = 2'd2;
        sValid  = 2'b01;
      end
      WIRE_ANTI_C3:
      begin
        sValid = 2'b01;
        pA     = 2'd2;
        pB     = 2'd1;
      end
      default:
      begin
        sValid = 2'b00;
      end
    endcase
  end

  assign ea       = {edgeAny[aIdx[1]], edgeAny[aIdx[0]]};
  assign eb       = {edgeAny[bIdx[1]], edgeAny[bIdx[0]]};
  assign sensNum  = (cfgWiring == WIRE_TWO_AB) ? 2'b01 : {cfgSecondSensor, ~cfgSecondSensor};
  assign noDirNow = |(sValid & cfgDirSensor & ~st_reg.dirKnown);

  // ==========================================================================
  // fault evaluation
  always_comb
  begin
    st_next = st_reg;
    if (errClear)
    begin
      st_next.freqMask = 4'h0;
      st_next.phase    = 2'b00;
      st_next.fdiff    = 2'b00;
      st_next.compl    = 4'h0;
      st_next.dirDisc  = 1'b0;
    end
    st_next.freqMask = st_next.freqMask | overFreq;
    for (int k = 0; k < 2; k++)
    begin
      if (sValid[k])
      begin
        if (ea[k] || eb[k])
          st_next.phCnt[k] = 8'h00;
        else if (st_reg.phCnt[k] != 8'hFF)
          st_next.phCnt[k] = st_reg.phCnt[k] + 8'h01;
        if (ea[k] && eb[k])
          st_next.phase[k] = 1'b1;
        else if ((ea[k] || eb[k]) && st_reg.phCnt[k] < PHASE_CYC[7:0])
          st_next.phase[k] = 1'b1;
        if (ea[k] ^ eb[k])
        begin
          st_next.lastB[k] = eb[k];
          if (eb[k] == st_reg.lastB[k])
          begin
            if (st_reg.runCnt[k] != 2'd3)
              st_next.runCnt[k] = st_reg.runCnt[k] + 2'd1;
            if (st_next.runCnt[k] >= FDIFF_RUN[1:0])
              st_next.fdiff[k] = 1'b1;
          end
          else
          begin
            st_next.runCnt[k]   = 2'd0;
            st_next.dirKnown[k] = 1'b1;
          end
        end
      end
    end
    // direction from true tracks versus complement tracks
    if (sValid[0] && useCompl)
    begin
      if (rise[0])
      begin
        st_next.dirT  = ~lvl[bIdx[0]];
        st_next.dirTv = 1'b1;
      end
      if (fall[pA])
      begin
        st_next.dirC  = lvl[3];
        st_next.dirCv = 1'b1;
      end
      if (st_next.dirTv && st_next.dirCv)
      begin
        if (st_next.dirT != st_next.dirC)
          st_next.dirDisc = 1'b1;
        st_next.dirTv = 1'b0;
        st_next.dirCv = 1'b0;
      end
    end
    // complement pairs must stay antivalent
    if (useCompl && lvl[0] == lvl[pA])
      st_next.discA = (st_reg.discA == 8'hFF) ? 8'hFF : st_reg.discA + 8'h01;
    else
      st_next.discA = 8'h00;
    if (useCompl && lvl[pB] == lvl[3])
      st_next.discB = (st_reg.discB == 8'hFF) ? 8'hFF : st_reg.discB + 8'h01;
    else
      st_next.discB = 8'h00;
    if (st_reg.discA >= DISC_N[7:0])
    begin
      if (cfgWiring == WIRE_TWO_ANTI || (cfgWiring == WIRE_ANTI_C2 && !cfgSecondSensor))
        st_next.compl[0] = 1'b1;
      else if (!cfgSecondSensor)
        st_next.compl[1] = 1'b1;
      else
        st_next.compl[2] = 1'b1;
    end
    if (st_reg.discB >= DISC_N[7:0])
    begin
      if (cfgWiring == WIRE_TWO_ANTI)
        st_next.compl[2] = 1'b1;
      else
        st_next.compl[3] = 1'b1;
    end
    st_next.flags[FLG_FREQ]    = |st_next.freqMask;
    st_next.flags[FLG_STUCK]   = |stuckByte;
    st_next.flags[FLG_PHASE]   = |st_next.phase;
    st_next.flags[FLG_DIRDISC] = st_next.dirDisc;
    st_next.flags[FLG_COMPL]   = |st_next.compl;
    st_next.flags[FLG_FDIFF]   = |st_next.fdiff;
    st_next.flags[FLG_NODIR]   = noDirNow;
    st_next.any = |st_next.flags;
    st_next.rel = releaseReq & ~{2{st_next.any}};
    // highest-priority active fault as a 32-bit code
    if (st_next.flags[FLG_FREQ])
      st_next.code = CODE_FREQ_BASE | {28'h0, st_next.freqMask};
    else if (st_next.flags[FLG_STUCK])
      st_next.code = CODE_STUCK_BASE | {24'h0, stuckByte};
    else if (st_next.flags[FLG_PHASE])
      st_next.code = (st_next.phase[0] && sensNum[0]) ? CODE_PHASE_S1 : CODE_PHASE_S2;
    else if (st_next.flags[FLG_DIRDISC])
      st_next.code = sensNum[0] ? CODE_DIR_S1 : CODE_DIR_S2;
    else if (st_next.compl[0])
      st_next.code = CODE_A1C_IN2;
    else if (st_next.compl[1])
      st_next.code = CODE_A1C_IN3;
    else if (st_next.compl[2])
      st_next.code = CODE_A2C;
    else if (st_next.compl[3])
      st_next.code = CODE_BC;
    else if (st_next.flags[FLG_FDIFF])
      st_next.code = (st_next.fdiff[0] && sensNum[0]) ? CODE_FDIFF_S1 : CODE_FDIFF_S2;
    else if (st_next.flags[FLG_NODIR])
      st_next.code = CODE_NODIR;
    else
      st_next.code = CODE_NONE;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign releaseOut = st_reg.rel;
  assign errAny     = st_reg.any;
  assign errCode    = st_reg.code;
  assign errFlags   = st_reg.flags;
  assign stuckCause = stuckByte;
  assign freqMask   = st_reg.freqMask;

  // ==========================================================================
  // assertions
  property p_freq_set;
    @(posedge clk) disable iff (!arst_n) overFreq[0] |=> freqMask[0] && errFlags[FLG_FREQ];
  endproperty
  a_freq_set: assert property (p_freq_set) else $error("input over limit not latched");
  property p_freq_code;
    @(posedge clk) disable iff (!arst_n) errFlags[FLG_FREQ] |-> errCode == (32'h2310_0210 | {28'h0, freqMask});
  endproperty
  a_freq_code: assert property (p_freq_code) else $error("combined frequency code wrong");
  property p_nodir;
    @(posedge clk) disable iff (!arst_n) (sValid[0] && cfgDirSensor[0] && !st_reg.dirKnown[0]) |=> errFlags[FLG_NODIR];
  endproperty
  a_nodir: assert property (p_nodir) else $error("no-direction flag missing");
  property p_stuck_code;
    @(posedge clk) disable iff (!arst_n) errCode[31:8] == 24'h231003 |-> errCode[7:0] == $past(stuckCause);
  endproperty
  a_stuck_code: assert property (p_stuck_code) else $error("stuck cause byte wrong");
  property p_phase_same;
    @(posedge clk) disable iff (!arst_n) (sValid[0] && ea[0] && eb[0]) |=> st_reg.phase[0] ##0 errFlags[FLG_PHASE];
  endproperty
  a_phase_same: assert property (p_phase_same) else $error("coincident edges not a phase fault");
  property p_compl;
    @(posedge clk) disable iff (!arst_n) (st_reg.discA >= DISC_N[7:0] && !errClear) |=> errFlags[FLG_COMPL];
  endproperty
  a_compl: assert property (p_compl) else $error("complement mismatch not flagged");
  property p_any;
    @(posedge clk) disable iff (!arst_n) (errAny == (errFlags != 7'h00)) && (errAny == (errCode != 32'h0));
  endproperty
  a_any: assert property (p_any) else $error("collective error inconsistent");
  property p_release;
    @(posedge clk) disable iff (!arst_n) errAny |-> releaseOut == 2'b00;
  endproperty
  a_release: assert property (p_release) else $error("release active during fault");
  property p_set_wins;
    @(posedge clk) disable iff (!arst_n) (errClear && overFreq[1]) |=> freqMask[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost at clear");
  c_combo: cover property (@(posedge clk) disable iff (!arst_n) freqMask == 4'h5);
  c_stuck: cover property (@(posedge clk) disable iff (!arst_n) errFlags[FLG_STUCK]);
  c_phase: cover property (@(posedge clk) disable iff (!arst_n) errCode == 32'h2310_0221);
  c_nodir: cover property (@(posedge clk) disable iff (!arst_n) errCode == 32'h2310_0404);
endmodule
`default_nettype wire

// ---- design/eifd_pkg.sv ----
package eifd_pkg;
  // ==========================================================================
  // timing
  localparam int CLK_NS         = 40;
  localparam int FREQ_GAP_NS    = 200;
  localparam int FREQ_GAP_CYC   = (FREQ_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PHASE_MIN_NS   = 120;
  localparam int PHASE_MIN_CYC  = (PHASE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int DISC_NS        = 2000;
  localparam int DISC_CYC       = (DISC_NS + CLK_NS - 1) / CLK_NS;
  localparam int STUCK_EDGES    = 4;
  localparam int FDIFF_RUN      = 3;

  // ==========================================================================
  // error codes
  localparam logic [31:0] CODE_NONE      = 32'h0000_0000;
  localparam logic [31:0] CODE_FREQ_BASE = 32'h2310_0210;
  localparam logic [31:0] CODE_DIR_S1    = 32'h2310_0204;
  localparam logic [31:0] CODE_DIR_S2    = 32'h2310_0205;
  localparam logic [31:0] CODE_A1C_IN2   = 32'h2310_0231;
  localparam logic [31:0] CODE_A1C_IN3   = 32'h2310_0232;
  localparam logic [31:0] CODE_A2C       = 32'h2310_0234;
  localparam logic [31:0] CODE_BC        = 32'h2310_0238;
  localparam logic [31:0] CODE_FDIFF_S1  = 32'h2310_0241;
  localparam logic [31:0] CODE_FDIFF_S2  = 32'h2310_0242;
  localparam logic [31:0] CODE_PHASE_S1  = 32'h2310_0221;
  localparam logic [31:0] CODE_PHASE_S2  = 32'h2310_0222;
  localparam logic [31:0] CODE_STUCK_BASE = 32'h2310_0300;
  localparam logic [31:0] CODE_NODIR     = 32'h2310_0404;

  // ==========================================================================
  // flag positions in errFlags
  localparam int FLG_FREQ    = 0;
  localparam int FLG_STUCK   = 1;
  localparam int FLG_PHASE   = 2;
  localparam int FLG_DIRDISC = 3;
  localparam int FLG_COMPL   = 4;
  localparam int FLG_FDIFF   = 5;
  localparam int FLG_NODIR   = 6;
  localparam int NUM_FLAGS   = 7;

  // ==========================================================================
  // input wiring
  typedef enum logic [1:0] {
    WIRE_TWO_AB   = 2'b00,
    WIRE_ANTI_C2  = 2'b01,
    WIRE_ANTI_C3  = 2'b10,
    WIRE_TWO_ANTI = 2'b11
  } eifd_wiring_t;
endpackage

// ---- design/eifd_track_mon.sv ----
`timescale 1ns/10ps
`default_nettype none
module eifd_track_mon
  import eifd_pkg::*;
#(
  parameter int GAP_CYC = FREQ_GAP_CYC,
  parameter int STUCK_N = STUCK_EDGES
)
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic pinIn,
  input  wire logic partnerEdge,
  input  wire logic clear,
  output logic      level,
  output logic      rise,
  output logic      fall,
  output logic      overFreq,
  output logic      stuckHigh,
  output logic      stuckLow
);
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       prev;
    logic [7:0] gap;
    logic [3:0] pCnt;
    logic       hi;
    logic       lo;
  } eifd_mon_t;

  eifd_mon_t st_reg;
  eifd_mon_t st_next;
  logic      edgeSeen;

  if (GAP_CYC < 1 || GAP_CYC > 254 || STUCK_N < 1 || STUCK_N > 14)
  begin : g_chk
    $error("eifd_track_mon: parameter out of range");
  end

  assign edgeSeen  = st_reg.s2 ^ st_reg.prev;
  assign level     = st_reg.s2;
  assign rise      = st_reg.s2 & ~st_reg.prev;
  assign fall      = ~st_reg.s2 & st_reg.prev;
  assign overFreq  = edgeSeen && (st_reg.gap < GAP_CYC[7:0]);
  assign stuckHigh = st_reg.hi;
  assign stuckLow  = st_reg.lo;

  always_comb
  begin
    st_next      = st_reg;
    st_next.s1   = pinIn;
    st_next.s2   = st_reg.s1;
    st_next.prev = st_reg.s2;
    if (edgeSeen)
      st_next.gap = 8'h00;
    else if (st_reg.gap != 8'hFF)
      st_next.gap = st_reg.gap + 8'h01;
    // partner edges counted while this track stays still
    if (edgeSeen)
      st_next.pCnt = 4'h0;
    else if (partnerEdge && st_reg.pCnt != 4'hF)
      st_next.pCnt = st_reg.pCnt + 4'h1;
    if (clear)
    begin
      st_next.hi = 1'b0;
      st_next.lo = 1'b0;
    end
    if (st_reg.pCnt >= STUCK_N[3:0])
    begin
      if (st_reg.s2)
        st_next.hi = 1'b1;
      else
        st_next.lo = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_reg <= '{s1: 1'b0, s2: 1'b0, prev: 1'b0, gap: 8'hFF, pCnt: 4'h0, hi: 1'b0, lo: 1'b0};
    else
      st_reg <= st_next;
  end
endmodule
`default_nettype wire

// ---- test/eifd_sensor_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module eifd_sensor_model
  import eifd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [1:0] wiring,
  input  wire logic [3:0] toggleMask,
  input  wire logic [1:0] complMask,
  output logic      [3:0] encIn
);
  logic [3:0] trackReg;

  // ==========================================================================
  // track levels, moved just after the rising edge
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      trackReg <= 4'h0;
    else
      trackReg <= trackReg ^ toggleMask;
  end

  // ==========================================================================
  // antivalent pins follow their true track while enabled, else move on their own
  always_comb
  begin
    encIn = trackReg;
    if (wiring == 2'h2)
    begin
      if (complMask[0])
        encIn[2] = ~trackReg[0];
      if (complMask[1])
        encIn[3] = ~trackReg[1];
    end
    else if (wiring != 2'h0)
    begin
      if (complMask[0])
        encIn[1] = ~trackReg[0];
      if (complMask[1])
        encIn[3] = ~trackReg[2];
    end
  end
endmodule
`default_nettype wire

// ---- test/eifd_diag_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    totalChecks++; \
    if ((got) !== (exp)) \
    begin \
      nErrors++; \
      $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end \
  end
module eifd_diag_tb
  import eifd_pkg::*;
();
  logic        clk;
  logic        arst_n;
  logic [3:0]  encIn;
  logic [3:0]  toggleMask;
  logic [1:0]  cfgWiring;
  logic [1:0]  cfgDirSensor;
  logic [1:0]  complMask;
  logic [1:0]  releaseReq;
  logic [1:0]  releaseOut;
  logic        cfgSecondSensor;
  logic        errClear;
  logic        errAny;
  logic [31:0] errCode;
  logic [6:0]  errFlags;
  logic [7:0]  stuckCause;
  logic [3:0]  freqMask;
  int          nErrors;
  int          totalChecks;
  logic [31:0] freqCodes [6] = '{32'h2310_0211, 32'h2310_0212, 32'h2310_0214,
                                 32'h2310_0215, 32'h2310_0218, 32'h2310_021A};
  logic [3:0]  freqPins  [6] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h8, 4'hA};
  // wiring, second sensor, complement mask, expected code
  logic [36:0] complTab  [6] = '{{2'h1, 1'b0, 2'h0, 32'h2310_0231}, {2'h2, 1'b0, 2'h0, 32'h2310_0232},
                                 {2'h3, 1'b0, 2'h0, 32'h2310_0231}, {2'h1, 1'b1, 2'h0, 32'h2310_0234},
                                 {2'h1, 1'b0, 2'h1, 32'h2310_0238}, {2'h3, 1'b0, 2'h1, 32'h2310_0234}};

  eifd_diag eifd_diag_inst (
    .clk             (clk),
    .arst_n          (arst_n),
    .encIn           (encIn),
    .cfgWiring       (cfgWiring),
    .cfgDirSensor    (cfgDirSensor),
    .cfgSecondSensor (cfgSecondSensor),
    .errClear        (errClear),
    .releaseReq      (releaseReq),
    .releaseOut      (releaseOut),
    .errAny          (errAny),
    .errCode         (errCode),
    .errFlags        (errFlags),
    .stuckCause      (stuckCause),
    .freqMask        (freqMask)
  );

  eifd_sensor_model eifd_sensor_model_inst (
    .clk        (clk),
    .arst_n     (arst_n),
    .wiring     (cfgWiring),
    .toggleMask (toggleMask),
    .complMask  (complMask),
    .encIn      (encIn)
  );

  // ==========================================================================
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    nErrors++;
    wrapUp();
  end

  // ==========================================================================
  // tasks
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic restart(input logic [1:0] w, input logic [1:0] d, input logic s, input logic [1:0] c);
    @(negedge clk);
    arst_n = 1'b0;
    cfgWiring = w;
    cfgDirSensor = d;
    cfgSecondSensor = s;
    complMask = c;
    toggleMask = 4'h0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
  endtask

  task automatic step(input logic [3:0] m, input int gap);
    @(negedge clk);
    toggleMask = m;
    @(negedge clk);
    toggleMask = 4'h0;
    repeat (gap - 2) @(negedge clk);
  endtask

  task automatic waitCode(input string nm, input logic [31:0] exp, input int lim);
    int i;
    for (i = 0; i < lim && errCode !== exp; i++)
      @(negedge clk);
    `CHK(nm, exp, errCode)
  endtask

  // ==========================================================================
  // tests
  initial
  begin
    arst_n = 1'b0;
    toggleMask = 4'h0;
    cfgWiring = 2'h0;
    cfgDirSensor = 2'h0;
    cfgSecondSensor = 1'b0;
    complMask = 2'h0;
    releaseReq = 2'h3;
    errClear = 1'b0;
    nErrors = 0;
    totalChecks = 0;

    restart(2'h0, 2'h0, 1'b0, 2'h0);
    repeat (6) @(negedge clk);
    `CHK("idle code", 32'h0, errCode)
    `CHK("idle collective", 1'b0, errAny)
    `CHK("idle release", 2'h3, releaseOut)
    releaseReq = 2'h1;
    repeat (2) @(negedge clk);
    `CHK("idle release one", 2'h1, releaseOut)
    releaseReq = 2'h3;
    $display("test idle done");

    for (int i = 0; i < 6; i++)
    begin
      restart(2'h0, 2'h0, 1'b0, 2'h0);
      step(freqPins[i], 2);
      step(freqPins[i], 8);
      waitCode("freq code", freqCodes[i], 40);
      `CHK("freq mask", freqPins[i], freqMask)
      `CHK("freq flag", 1'b1, errFlags[FLG_FREQ])
      `CHK("freq collective", 1'b1, errAny)
      `CHK("freq release", 2'h0, releaseOut)
    end
    @(negedge clk);
    errClear = 1'b1;
    repeat (2) @(negedge clk);
    errClear = 1'b0;
    waitCode("cleared code", 32'h0, 20);
    repeat (3) @(negedge clk);
    `CHK("cleared collective", 1'b0, errAny)
    `CHK("cleared release", 2'h3, releaseOut)
    // second close edge is seen in the very cycle that clears
    restart(2'h0, 2'h0, 1'b0, 2'h0);
    step(4'h2, 2);
    @(negedge clk);
    toggleMask = 4'h2;
    @(negedge clk);
    toggleMask = 4'h0;
    @(negedge clk);
    @(negedge clk);
    errClear = 1'b1;
    @(negedge clk);
    errClear = 1'b0;
    waitCode("set beats clear", 32'h2310_0212, 10);
    `CHK("set beats clear mask", 4'h2, freqMask)
    $display("test frequency done");

    restart(2'h0, 2'h1, 1'b0, 2'h0);
    waitCode("no direction", 32'h2310_0404, 10);
    `CHK("nodir flag", 1'b1, errFlags[FLG_NODIR])
    `CHK("nodir collective", 1'b1, errAny)
    `CHK("nodir release", 2'h0, releaseOut)
    step(4'h1, 8);
    step(4'h2, 8);
    step(4'h1, 8);
    step(4'h2, 8);
    waitCode("moved code", 32'h0, 20);
    repeat (3) @(negedge clk);
    `CHK("moved release", 2'h3, releaseOut)
    $display("test direction known done");

    restart(2'h0, 2'h0, 1'b0, 2'h0);
    repeat (5) step(4'h1, 16);
    waitCode("stuck low", 32'h2310_0308, 40);
    `CHK("stuck low cause", 8'h08, stuckCause)
    `CHK("stuck flag", 1'b1, errFlags[FLG_STUCK])
    restart(2'h0, 2'h0, 1'b0, 2'h0);
    step(4'h8, 16);
    repeat (5) step(4'h4, 16);
    waitCode("stuck high", 32'h2310_0340, 40);
    `CHK("stuck high cause", 8'h40, stuckCause)
    $display("test stuck done");

    for (int s = 0; s < 2; s++)
    begin
      restart(2'h0, 2'h0, 1'b0, 2'h0);
      step(s ? 4'hC : 4'h3, 8);
      waitCode("phase code", s ? 32'h2310_0222 : 32'h2310_0221, 30);
      `CHK("phase flag", 1'b1, errFlags[FLG_PHASE])
      restart(2'h0, 2'h0, 1'b0, 2'h0);
      repeat (3) step(s ? 4'h4 : 4'h1, 16);
      waitCode("freq diff code", s ? 32'h2310_0242 : 32'h2310_0241, 30);
      `CHK("freq diff flag", 1'b1, errFlags[FLG_FDIFF])
    end
    $display("test phase and freq difference done");

    for (int i = 0; i < 6; i++)
    begin
      restart(complTab[i][36:35], 2'h0, complTab[i][34], complTab[i][33:32]);
      waitCode("complement code", complTab[i][31:0], 120);
      `CHK("complement flag", 1'b1, errFlags[FLG_COMPL])
    end
    $display("test complement done");

    for (int s = 0; s < 2; s++)
    begin
      restart(2'h1, 2'h0, s[0], 2'h0);
      step(4'h2, 8);
      step(4'h8, 8);
      step(4'h1, 8);
      step(4'h8, 8);
      step(4'h4, 8);
      step(4'h2, 8);
      waitCode("dir discrepancy", s ? 32'h2310_0205 : 32'h2310_0204, 30);
      `CHK("dir discrepancy flag", 1'b1, errFlags[FLG_DIRDISC])
    end
    $display("test dir discrepancy done");

    wrapUp();
  end
endmodule
`default_nettype wire
